/* dv/ssr_panel_model.sv */
// Behavioural car and hall panel boards on the bus side of the block
`timescale 1ns/1ps
module ssr_panel_model (
  input wire logic clk_i,
  input wire logic door_req_i,
  input wire logic [2:0] door_cmd_i,
  input wire logic hall_req_i,
  input wire logic hall_sel_i,
  input wire logic [1:0] hall_spare_i,
  output logic door_valid_o,
  output logic door_close_o,
  output logic door_open1_o,
  output logic door_open2_o,
  output logic hall_valid_o,
  output logic hall_sel_o,
  output logic [1:0] hall_spare_o
);
  logic [2:0] junk_reg = 3'h5;
  // Bits outside a strobe keep moving so stale data never looks valid
  always_ff @(posedge clk_i) begin
    junk_reg <= junk_reg + 3'h3;
    door_valid_o <= door_req_i;
    door_close_o <= door_req_i ? door_cmd_i[0] : junk_reg[0];
    door_open1_o <= door_req_i ? door_cmd_i[1] : ~junk_reg[0];
    door_open2_o <= door_req_i ? door_cmd_i[2] : junk_reg[1];
    hall_valid_o <= hall_req_i;
    // Select bit follows hall_sel_i, so this one model plays both a selected and an unselected panel
    hall_sel_o <= hall_req_i ? hall_sel_i : junk_reg[2];
    hall_spare_o <= hall_req_i ? hall_spare_i : junk_reg[1:0];
  end
endmodule : ssr_panel_model

/* dv/tb_ssr_top.sv */
// Self-checking bench for the serial signal reduction block
`timescale 1ns/1ps
module tb_ssr_top;
  typedef struct {int at; int sel; logic [3:0] exp;} ssr_note_t;
  ssr_note_t notes[$];
  ssr_note_t nt;
  string names[8] = '{"limits", "car_relays", "board_relays", "hall_modes",
    "setup_state", "lamp", "beeps", "nv_writes"};
  int checks = 0, n_fail = 0, cyc = 0;
  logic clk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1;
  logic limit_synthesis_enable_i = 1'b0, top_terminal_i = 1'b0;
  logic bottom_terminal_i = 1'b0, up_door_zone_i = 1'b0;
  logic down_door_zone_i = 1'b0, wired_top_limit_i = 1'b0;
  logic wired_bottom_limit_i = 1'b0, open1_btn_i = 1'b0;
  logic [3:0] jumper_i = 4'h0;
  logic nv_setting_i = 1'b0, serial_lock_enable_i = 1'b0;
  logic serial_lock_invert_i = 1'b0, serial_fire_enable_i = 1'b0;
  logic serial_fire_invert_i = 1'b0, local_lock_input_i = 1'b0;
  logic local_fire_input_i = 1'b0;
  logic door_req = 1'b0, hall_req = 1'b0, hall_sel = 1'b0;
  logic [2:0] door_cmd = 3'h0;
  logic [1:0] hall_spare = 2'h0, w;
  logic can_door_valid_i, can_door_close_i, can_door_open1_i;
  logic can_door_open2_i, hall_frame_valid_i, hall_select_ok_i;
  logic [1:0] hall_spare_i;
  logic top_limit_o, bottom_limit_o, door_open1_lamp_o, buzzer_o;
  logic nv_write_o, nv_data_o, setting_mode_o, door_serial_en_o;
  logic car_close_relay_o, car_open1_relay_o, car_open2_relay_o;
  logic [3:0] board_door_relays_o, beeps = 4'h0, nv_writes = 4'h0, v, r;
  logic hall_link_ok_o, lock_mode_o, fire_mode_o, buz_d = 1'b0, lk, fr;
  logic [3:0] got;
  logic [2:0] flashes = 3'h0;
  logic lamp_d = 1'b0;

  ssr_panel_model panel_u (.clk_i(clk_i), .door_req_i(door_req),
    .door_cmd_i(door_cmd), .hall_req_i(hall_req), .hall_sel_i(hall_sel),
    .hall_spare_i(hall_spare), .door_valid_o(can_door_valid_i),
    .door_close_o(can_door_close_i), .door_open1_o(can_door_open1_i),
    .door_open2_o(can_door_open2_i), .hall_valid_o(hall_frame_valid_i),
    .hall_sel_o(hall_select_ok_i), .hall_spare_o(hall_spare_i));

  ssr_top #(.BEEP_HALF_CYC(4), .LINK_TIMEOUT_CYC(8)) dut_u (.clk_i,
    .arst_n_i, .ce_i, .limit_synthesis_enable_i, .top_terminal_i,
    .bottom_terminal_i, .up_door_zone_i, .down_door_zone_i,
    .wired_top_limit_i, .wired_bottom_limit_i, .top_limit_o,
    .bottom_limit_o, .jumper_i, .open1_btn_i, .nv_setting_i,
    .door_open1_lamp_o, .buzzer_o, .nv_write_o, .nv_data_o, .setting_mode_o,
    .door_serial_en_o, .can_door_valid_i, .can_door_close_i,
    .can_door_open1_i, .can_door_open2_i, .car_close_relay_o,
    .car_open1_relay_o, .car_open2_relay_o, .board_door_relays_o,
    .hall_frame_valid_i, .hall_select_ok_i, .hall_spare_i,
    .serial_lock_enable_i, .serial_lock_invert_i, .serial_fire_enable_i,
    .serial_fire_invert_i, .local_lock_input_i, .local_fire_input_i,
    .hall_link_ok_o, .lock_mode_o, .fire_mode_o);

  always #4 clk_i = ~clk_i;

  task automatic complete_run;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Counts beeps and plays the nonvolatile memory behind the car panel
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    buz_d <= buzzer_o;
    if (buzzer_o === 1'b1 && buz_d === 1'b0) beeps <= beeps + 4'h1;
    lamp_d <= door_open1_lamp_o;
    if (door_open1_lamp_o === 1'b0 && lamp_d === 1'b1)
      flashes <= flashes + 3'h1;
    if (nv_write_o === 1'b1) begin
      nv_writes <= nv_writes + 4'h1;
      nv_setting_i <= nv_data_o;
    end
    if (cyc > 5000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  function automatic logic [3:0] obs(input int sel);
    case (sel)
      0: obs = {2'h0, bottom_limit_o, top_limit_o};
      1: obs = {1'h0, car_open2_relay_o, car_open1_relay_o, car_close_relay_o};
      2: obs = board_door_relays_o;
      3: obs = {1'h0, hall_link_ok_o, fire_mode_o, lock_mode_o};
      4: obs = {2'h0, setting_mode_o, door_serial_en_o};
      5: obs = {flashes, door_open1_lamp_o};
      6: obs = beeps;
      default: obs = nv_writes;
    endcase
  endfunction : obs

  // Results are settled by the falling edge
  always @(negedge clk_i) begin
    while (notes.size() > 0 && notes[0].at <= cyc) begin
      nt = notes.pop_front();
      checks = checks + 1;
      got = obs(nt.sel);
      if (got !== nt.exp) begin
        n_fail = n_fail + 1;
        $display("BAD %s exp %h got %h", names[nt.sel], nt.exp, got);
      end
    end
  end

  task automatic note(input int sel, input logic [3:0] exp, input int d);
    notes.push_back('{cyc + d, sel, exp});
  endtask : note

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic do_reset;
    arst_n_i <= 1'b0;
    step(12);
    arst_n_i <= 1'b1;
    step(4);
  endtask : do_reset

  task automatic door(input logic [2:0] c, input logic en);
    door_req <= 1'b1;
    door_cmd <= c;
    step(1);
    door_req <= 1'b0;
    note(1, en ? {1'h0, c} : 4'h0, 3);
    note(2, {|c, c}, 3);
    step(4);
  endtask : door

  task automatic hall(input logic s, input logic [1:0] sp, input logic [3:0] e);
    hall_req <= 1'b1;
    hall_sel <= s;
    hall_spare <= sp;
    step(1);
    hall_req <= 1'b0;
    note(3, e, 4);
    step(4);
  endtask : hall

  initial begin
    void'($urandom(32'h4d4efd76));
    do_reset();
    note(4, 4'h0, 2);
    for (int i = 0; i < 32; i++) begin
      v = 4'(i);
      w = 2'($urandom);
      limit_synthesis_enable_i <= i[4];
      {top_terminal_i, bottom_terminal_i} <= v[3:2];
      {up_door_zone_i, down_door_zone_i} <= v[1:0];
      {wired_top_limit_i, wired_bottom_limit_i} <= w;
      if (i[4]) note(0, {2'h0, v[2] & v[1] & ~v[0], v[3] & v[0] & ~v[1]}, 3);
      else note(0, {2'h0, w[0], w[1]}, 3);
      step(3);
    end
    // Clock enable low must freeze the limits
    ce_i <= 1'b0;
    {up_door_zone_i, bottom_terminal_i} <= 2'h0;
    step(3);
    note(0, 4'h0, 1);
    ce_i <= 1'b1;
    step(3);
    note(0, 4'h1, 1);
    for (int i = 0; i < 8; i++) door(3'(i), 1'b0);
    // Jumper D fitted must not open the setting mode
    jumper_i <= 4'hF;
    step(10);
    note(4, 4'h0, 1);
    jumper_i <= 4'h7;
    for (int k = 0; k < 50 && setting_mode_o !== 1'b1; k++) step(1);
    note(4, 4'h2, 1);
    step(30);
    note(6, 4'h2, 1);
    open1_btn_i <= 1'b1;
    step(2);
    open1_btn_i <= 1'b0;
    note(5, 4'h1, 4);
    step(6);
    jumper_i <= 4'h0;
    for (int k = 0; k < 200 && nv_writes === 4'h0; k++) step(1);
    step(4);
    note(7, 4'h1, 1);
    note(6, 4'h5, 1);
    note(4, 4'h1, 1);
    note(5, 4'h6, 1);
    step(2);
    for (int i = 0; i < 8; i++) door(3'(i), 1'b1);
    do_reset();
    note(4, 4'h1, 4);
    for (int i = 0; i < 16; i++) begin
      r = 4'($urandom);
      {serial_lock_enable_i, serial_lock_invert_i} <= 2'(i >> 2);
      {serial_fire_enable_i, serial_fire_invert_i} <= 2'(i);
      local_lock_input_i <= r[2];
      local_fire_input_i <= r[3];
      lk = i[3] ? r[0] ^ i[2] : r[2];
      fr = i[1] ? (r[1] ^ i[0]) | r[3] : r[3];
      hall(1'b1, r[1:0], {2'h1, fr, lk});
    end
    {serial_lock_enable_i, serial_lock_invert_i} <= 2'h2;
    {serial_fire_enable_i, serial_fire_invert_i} <= 2'h2;
    local_fire_input_i <= 1'b1;
    step(16);
    note(3, 4'h0, 1);
    step(2);
    hall(1'b1, 2'h3, 4'h7);
    hall(1'b0, 2'h3, 4'h0);
    step(4);
    complete_run();
  end
endmodule : tb_ssr_top

/* src/ssr_car_setup.sv */
// Car panel setting mode for the serial door control enable
`timescale 1ns/1ps
module ssr_car_setup #(
  parameter int unsigned BEEP_HALF_CYC = ssr_pkg::BEEP_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] jumper_i,
  input wire logic open1_btn_i,
  input wire logic nv_setting_i,
  output logic door_en_o,
  output logic lamp_o,
  output logic buzzer_o,
  output logic nv_write_o,
  output logic nv_data_o,
  output logic setting_mode_o
);
  ssr_pkg::ssr_setup_state_t state_reg;
  logic [31:0] tone_cnt_reg;
  logic [2:0] half_reg;
  logic loaded_reg, stored_reg, edit_reg, btn_q_reg;
  logic tone_wrap, tone_done, press, jumpers_set, sounding;

  assign jumpers_set = jumper_i == ssr_pkg::SETUP_JUMPERS;
  assign sounding = state_reg == ssr_pkg::SU_INTRO
    || state_reg == ssr_pkg::SU_OUTRO;
  assign tone_wrap = tone_cnt_reg == 32'(BEEP_HALF_CYC - 1);
  assign tone_done = tone_wrap && half_reg == 3'h1;
  assign press = open1_btn_i & ~btn_q_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ssr_pkg::SU_IDLE;
      tone_cnt_reg <= 32'h0;
      half_reg <= 3'h0;
    end else if (ce_i) begin
      tone_cnt_reg <= (!sounding || tone_wrap) ? 32'h0
        : tone_cnt_reg + 32'h1;
      if (sounding && tone_wrap)
        half_reg <= half_reg - 3'h1;
      unique case (state_reg)
        ssr_pkg::SU_IDLE: if (loaded_reg && jumpers_set) begin
          state_reg <= ssr_pkg::SU_INTRO; // RULE4
          half_reg <= ssr_pkg::ENTER_HALVES;
        end
        ssr_pkg::SU_INTRO: if (tone_done) begin
          state_reg <= ssr_pkg::SU_SET;
        end
        ssr_pkg::SU_SET: if (!jumpers_set) begin
          state_reg <= ssr_pkg::SU_OUTRO; // RULE6
          half_reg <= ssr_pkg::EXIT_HALVES;
        end
        ssr_pkg::SU_OUTRO: if (tone_done) begin
          state_reg <= ssr_pkg::SU_SAVE;
        end
        ssr_pkg::SU_SAVE: state_reg <= ssr_pkg::SU_IDLE;
        default: state_reg <= ssr_pkg::SU_IDLE;
      endcase
    end
  end

  // Stored value is fetched once after reset, before setup is allowed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loaded_reg <= 1'h0;
      stored_reg <= ssr_pkg::NV_RESET_VALUE;
      edit_reg <= ssr_pkg::NV_RESET_VALUE;
      btn_q_reg <= 1'h0;
    end else if (ce_i) begin
      btn_q_reg <= open1_btn_i;
      if (!loaded_reg) begin
        loaded_reg <= 1'h1;
        stored_reg <= nv_setting_i; // RULE18
      end
      if (state_reg == ssr_pkg::SU_IDLE)
        edit_reg <= stored_reg;
      else if (state_reg == ssr_pkg::SU_SET && press)
        edit_reg <= ~edit_reg; // RULE5
      if (state_reg == ssr_pkg::SU_SAVE)
        stored_reg <= edit_reg; // RULE6
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      door_en_o <= ssr_pkg::NV_RESET_VALUE;
      lamp_o <= 1'h0;
      buzzer_o <= 1'h0;
      nv_write_o <= 1'h0;
      nv_data_o <= ssr_pkg::NV_RESET_VALUE;
      setting_mode_o <= 1'h0;
    end else if (ce_i) begin
      door_en_o <= stored_reg;
      buzzer_o <= sounding & ~half_reg[0]; // RULE4
      lamp_o <= (state_reg == ssr_pkg::SU_SET && edit_reg)
        || (state_reg == ssr_pkg::SU_OUTRO && edit_reg
        && !half_reg[0]); // RULE5
      nv_write_o <= state_reg == ssr_pkg::SU_SAVE; // RULE18
      nv_data_o <= edit_reg;
      setting_mode_o <= state_reg != ssr_pkg::SU_IDLE;
    end
  end

  if (BEEP_HALF_CYC < 1) begin : g_bad_beep
    $error("BEEP_HALF_CYC must be at least 1");
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_enter_setup: assert property ( // RULE4
    ce_i && state_reg == ssr_pkg::SU_IDLE && loaded_reg && jumpers_set
      |=> state_reg == ssr_pkg::SU_INTRO && half_reg == 3'h4)
    else $error("setup pattern did not start setting mode");
  chk_button_toggle: assert property ( // RULE5
    ce_i && state_reg == ssr_pkg::SU_SET && press
      |=> edit_reg != $past(edit_reg))
    else $error("door open 1 press did not toggle setting");
  chk_save_store: assert property ( // RULE6
    ce_i && state_reg == ssr_pkg::SU_SAVE |=> nv_write_o
      && nv_data_o == $past(edit_reg) && stored_reg == $past(edit_reg))
    else $error("setting not saved on exit");
  cov_save: cover property (nv_write_o && nv_data_o);
endmodule : ssr_car_setup

/* src/ssr_limit_synth.sv */
// Top and bottom limit generation from terminal and door zone inputs
`timescale 1ns/1ps
module ssr_limit_synth (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic limit_synthesis_enable_i,
  input wire logic top_terminal_i,
  input wire logic bottom_terminal_i,
  input wire logic up_door_zone_i,
  input wire logic down_door_zone_i,
  input wire logic wired_top_limit_i,
  input wire logic wired_bottom_limit_i,
  output logic top_limit_o,
  output logic bottom_limit_o
);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      top_limit_o <= 1'h0;
      bottom_limit_o <= 1'h0;
    end else if (ce_i) begin
      if (limit_synthesis_enable_i) begin
        // RULE3
        top_limit_o <= top_terminal_i & down_door_zone_i
          & ~up_door_zone_i; // RULE1
        bottom_limit_o <= bottom_terminal_i & up_door_zone_i
          & ~down_door_zone_i; // RULE2
      end else begin
        top_limit_o <= wired_top_limit_i;
        bottom_limit_o <= wired_bottom_limit_i;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_top_synth: assert property ( // RULE1
    ce_i && limit_synthesis_enable_i |=> top_limit_o ==
      $past(top_terminal_i & down_door_zone_i & ~up_door_zone_i))
    else $error("top limit not synthesised");
  chk_bottom_synth: assert property ( // RULE2
    ce_i && limit_synthesis_enable_i |=> bottom_limit_o ==
      $past(bottom_terminal_i & up_door_zone_i & ~down_door_zone_i))
    else $error("bottom limit not synthesised");
  chk_wired_ignored: assert property ( // RULE3
    ce_i && limit_synthesis_enable_i && !top_terminal_i
      |=> !top_limit_o)
    else $error("wired top limit leaked through");
endmodule : ssr_limit_synth

/* src/ssr_pkg.sv */
// Shared constants and types for the serial signal reduction block
package ssr_pkg;
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  // Buzzer and lamp half period of one beep or flash
  localparam int unsigned BEEP_HALF_MS = 100;
  localparam int unsigned BEEP_HALF_CYC = (CLK_FREQ_HZ / 1000) * BEEP_HALF_MS;
  // Hall panel link is lost when no frame arrives in this time
  localparam int unsigned LINK_TIMEOUT_MS = 200;
  localparam int unsigned LINK_TIMEOUT_CYC =
    (CLK_FREQ_HZ / 1000) * LINK_TIMEOUT_MS;
  // Jumper bits: 0..2 are jumpers 1..3, bit 3 is jumper D
  localparam logic [3:0] SETUP_JUMPERS = 4'h7;
  localparam logic [2:0] ENTER_BEEPS = 3'h2;
  localparam logic [2:0] EXIT_BEEPS = 3'h3;
  localparam logic [2:0] ENTER_HALVES = 3'(ENTER_BEEPS << 1);
  localparam logic [2:0] EXIT_HALVES = 3'(EXIT_BEEPS << 1);
  localparam logic NV_RESET_VALUE = 1'h0;
  // Spare input positions in the hall panel message
  localparam int SPARE_LOCK_BIT = 0;
  localparam int SPARE_FIRE_BIT = 1;
  // Board door relay bit positions
  localparam int BRD_CLOSE = 0;
  localparam int BRD_OPEN1 = 1;
  localparam int BRD_OPEN2 = 2;
  localparam int BRD_ANY = 3;
  typedef enum logic [2:0] {
    SU_IDLE,
    SU_INTRO,
    SU_SET,
    SU_OUTRO,
    SU_SAVE
  } ssr_setup_state_t;
endpackage : ssr_pkg

/* src/ssr_top.sv */
// Serial signal reduction: limits, car door relays, hall lock and fire
// Functional notes
// (RULE1) Synthesise top limit from terminal and zones
// (RULE2) Synthesise bottom limit from terminal and zones
// (RULE3) Synthesis enabled: wired limits are not used
// (RULE4) Jumpers 1-3 fitted, D open: setup, two beeps
// (RULE5) Open-1 lamp shows enable; press toggles it
// (RULE6) Jumpers removed: flash, beep three, store, exit
// (RULE7) Enabled: car relays follow bus door commands
// (RULE8) Board door relays mirror bus door commands
// (RULE9) Lock and fire travel in hall messages
// (RULE10) Exactly one hall panel selects serial source
// (RULE11) Spare input 0 lock, spare 1 fire
// (RULE12) Serial lock used only when enabled
// (RULE13) Lock invert flips received lock level
// (RULE14) Serial fire used only when enabled
// (RULE15) Fire invert flips received fire level
// (RULE16) Serial or local fire enters fire mode; with serial fire enabled, a lost link blocks local fire too
// (RULE17) Link missing: no lock or fire mode while the serial source is enabled; local inputs still drive them when disabled
// (RULE18) Door setting kept in nonvolatile storage
`timescale 1ns/1ps
module ssr_top #(
  parameter int unsigned BEEP_HALF_CYC = ssr_pkg::BEEP_HALF_CYC,
  parameter int unsigned LINK_TIMEOUT_CYC = ssr_pkg::LINK_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Hoistway limit synthesis
  input wire logic limit_synthesis_enable_i,
  input wire logic top_terminal_i,
  input wire logic bottom_terminal_i,
  input wire logic up_door_zone_i,
  input wire logic down_door_zone_i,
  input wire logic wired_top_limit_i,
  input wire logic wired_bottom_limit_i,
  output logic top_limit_o,
  output logic bottom_limit_o,
  // Car panel setup and storage
  input wire logic [3:0] jumper_i,
  input wire logic open1_btn_i,
  input wire logic nv_setting_i,
  output logic door_open1_lamp_o,
  output logic buzzer_o,
  output logic nv_write_o,
  output logic nv_data_o,
  output logic setting_mode_o,
  output logic door_serial_en_o,
  // Door commands received from the bus
  input wire logic can_door_valid_i,
  input wire logic can_door_close_i,
  input wire logic can_door_open1_i,
  input wire logic can_door_open2_i,
  output logic car_close_relay_o,
  output logic car_open1_relay_o,
  output logic car_open2_relay_o,
  output logic [3:0] board_door_relays_o,
  // Hall panel message and lock/fire settings
  input wire logic hall_frame_valid_i,
  input wire logic hall_select_ok_i,
  input wire logic [1:0] hall_spare_i,
  input wire logic serial_lock_enable_i,
  input wire logic serial_lock_invert_i,
  input wire logic serial_fire_enable_i,
  input wire logic serial_fire_invert_i,
  input wire logic local_lock_input_i,
  input wire logic local_fire_input_i,
  output logic hall_link_ok_o,
  output logic lock_mode_o,
  output logic fire_mode_o
);
  logic door_en;
  logic [2:0] door_cmd;
  logic [31:0] wd_cnt_reg;
  logic link_ok_reg;
  logic hall_lock_cmd_reg;
  logic hall_fire_cmd_reg;
  logic wd_expire;
  logic serial_lock;
  logic serial_fire;

  ssr_limit_synth u_limit (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .limit_synthesis_enable_i(limit_synthesis_enable_i),
    .top_terminal_i(top_terminal_i),
    .bottom_terminal_i(bottom_terminal_i),
    .up_door_zone_i(up_door_zone_i),
    .down_door_zone_i(down_door_zone_i),
    .wired_top_limit_i(wired_top_limit_i),
    .wired_bottom_limit_i(wired_bottom_limit_i),
    .top_limit_o(top_limit_o),
    .bottom_limit_o(bottom_limit_o)
  );

  ssr_car_setup #(
    .BEEP_HALF_CYC(BEEP_HALF_CYC)
  ) u_setup (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .jumper_i(jumper_i),
    .open1_btn_i(open1_btn_i),
    .nv_setting_i(nv_setting_i),
    .door_en_o(door_en),
    .lamp_o(door_open1_lamp_o),
    .buzzer_o(buzzer_o),
    .nv_write_o(nv_write_o),
    .nv_data_o(nv_data_o),
    .setting_mode_o(setting_mode_o)
  );

  assign door_cmd[ssr_pkg::BRD_CLOSE] = can_door_close_i;
  assign door_cmd[ssr_pkg::BRD_OPEN1] = can_door_open1_i;
  assign door_cmd[ssr_pkg::BRD_OPEN2] = can_door_open2_i;

  // Door relays; car relays share one common terminal outside
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      car_close_relay_o <= 1'h0;
      car_open1_relay_o <= 1'h0;
      car_open2_relay_o <= 1'h0;
      board_door_relays_o <= 4'h0;
      door_serial_en_o <= 1'h0;
    end else if (ce_i) begin
      door_serial_en_o <= door_en;
      if (!door_en) begin
        // Disabled: relays must not hold a stale command
        car_close_relay_o <= 1'h0;
        car_open1_relay_o <= 1'h0;
        car_open2_relay_o <= 1'h0;
      end else if (can_door_valid_i) begin
        car_close_relay_o <= door_cmd[ssr_pkg::BRD_CLOSE]; // RULE7
        car_open1_relay_o <= door_cmd[ssr_pkg::BRD_OPEN1];
        car_open2_relay_o <= door_cmd[ssr_pkg::BRD_OPEN2];
      end
      if (can_door_valid_i) begin
        board_door_relays_o <= {|door_cmd, door_cmd}; // RULE8
      end
    end
  end

  // Lock and fire bits latched only from a selected hall panel
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hall_lock_cmd_reg <= 1'h0;
      hall_fire_cmd_reg <= 1'h0;
    end else if (ce_i) begin
      if (hall_frame_valid_i && hall_select_ok_i) begin
        // RULE9
        hall_lock_cmd_reg <= hall_spare_i[ssr_pkg::SPARE_LOCK_BIT]; // RULE11
        hall_fire_cmd_reg <= hall_spare_i[ssr_pkg::SPARE_FIRE_BIT];
      end
    end
  end

  assign wd_expire = wd_cnt_reg == 32'(LINK_TIMEOUT_CYC - 1);

  // Link watchdog; counter parks at expiry so it cannot wrap back
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wd_cnt_reg <= 32'h0;
      link_ok_reg <= 1'h0;
      hall_link_ok_o <= 1'h0;
    end else if (ce_i) begin
      hall_link_ok_o <= link_ok_reg;
      if (hall_frame_valid_i) begin
        wd_cnt_reg <= 32'h0;
        // Open jumper on the panel counts as no source
        link_ok_reg <= hall_select_ok_i; // RULE10
      end else if (wd_expire) begin
        link_ok_reg <= 1'h0; // RULE17
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 32'h1;
      end
    end
  end

  // Inversion applies only while the link is good, else idle
  assign serial_lock = link_ok_reg
    & (hall_lock_cmd_reg ^ serial_lock_invert_i); // RULE13
  assign serial_fire = link_ok_reg
    & (hall_fire_cmd_reg ^ serial_fire_invert_i); // RULE15

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_mode_o <= 1'h0;
    end else if (ce_i) begin
      if (serial_lock_enable_i)
        lock_mode_o <= serial_lock; // RULE12
      else
        lock_mode_o <= local_lock_input_i;
    end
  end

  // With serial fire enabled, lost link blocks fire mode even with the local input active
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fire_mode_o <= 1'h0;
    end else if (ce_i) begin
      if (serial_fire_enable_i)
        fire_mode_o <= link_ok_reg
          & (serial_fire | local_fire_input_i); // RULE16
      else
        fire_mode_o <= local_fire_input_i; // RULE14
    end
  end

  if (LINK_TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("LINK_TIMEOUT_CYC must be at least 2");
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_relay_gate: assert property ( // RULE7
    ce_i && !door_en |=> !car_close_relay_o && !car_open1_relay_o
      && !car_open2_relay_o)
    else $error("car relay driven while serial door disabled");
  chk_relay_follow: assert property ( // RULE7
    ce_i && door_en && can_door_valid_i |=> car_open2_relay_o
      == $past(can_door_open2_i) && car_close_relay_o
      == $past(can_door_close_i))
    else $error("car relays did not follow bus command");
  chk_board_mirror: assert property ( // RULE8
    ce_i && door_en && can_door_valid_i
      |=> board_door_relays_o[2:0] == {car_open2_relay_o,
      car_open1_relay_o, car_close_relay_o}
      && board_door_relays_o[3] == |board_door_relays_o[2:0])
    else $error("board relays out of step with car relays");
  chk_spare_map: assert property ( // RULE11
    ce_i && hall_frame_valid_i && hall_select_ok_i
      |=> hall_lock_cmd_reg == $past(hall_spare_i[0])
      && hall_fire_cmd_reg == $past(hall_spare_i[1]))
    else $error("spare inputs mapped wrongly");
  chk_lock_gate: assert property ( // RULE12
    ce_i && !serial_lock_enable_i
      |=> lock_mode_o == $past(local_lock_input_i))
    else $error("lock mode not from local input when disabled");
  chk_lock_invert: assert property ( // RULE13
    ce_i && serial_lock_enable_i && link_ok_reg
      |=> lock_mode_o == $past(hall_lock_cmd_reg ^ serial_lock_invert_i))
    else $error("serial lock polarity wrong");
  chk_fire_gate: assert property ( // RULE14
    ce_i && !serial_fire_enable_i
      |=> fire_mode_o == $past(local_fire_input_i))
    else $error("fire mode not from local input when disabled");
  chk_fire_invert: assert property ( // RULE15
    ce_i && serial_fire_enable_i && link_ok_reg && !local_fire_input_i
      |=> fire_mode_o == $past(hall_fire_cmd_reg ^ serial_fire_invert_i))
    else $error("serial fire polarity wrong");
  chk_fire_either: assert property ( // RULE16
    ce_i && serial_fire_enable_i && link_ok_reg && local_fire_input_i
      |=> fire_mode_o)
    else $error("local fire ignored while serial fire enabled");
  chk_link_block: assert property ( // RULE17
    ce_i && !link_ok_reg && serial_lock_enable_i
      && serial_fire_enable_i |=> !lock_mode_o && !fire_mode_o)
    else $error("lock or fire mode entered without link");
  chk_link_timeout: assert property ( // RULE17
    ce_i && wd_expire && !hall_frame_valid_i |=> !link_ok_reg
      ##1 !(ce_i && serial_lock_enable_i) || !lock_mode_o)
    else $error("watchdog expiry did not drop the link");
  // Link, hold and freeze checks
  chk_frame_link: assert property ( // RULE17
    ce_i && hall_frame_valid_i |=> link_ok_reg == $past(hall_select_ok_i))
    else $error("link state not taken from frame select");
  chk_link_out: assert property ( // RULE17
    ce_i |=> hall_link_ok_o == $past(link_ok_reg))
    else $error("link status output not registered");
  chk_lock_lost: assert property ( // RULE17
    ce_i && serial_lock_enable_i && !link_ok_reg |=> !lock_mode_o)
    else $error("lock mode entered without link");
  chk_fire_lost: assert property ( // RULE17
    ce_i && serial_fire_enable_i && !link_ok_reg |=> !fire_mode_o)
    else $error("fire mode entered without link");
  chk_unselected: assert property ( // RULE10
    ce_i && hall_frame_valid_i && !hall_select_ok_i
      |=> $stable(hall_lock_cmd_reg) && $stable(hall_fire_cmd_reg))
    else $error("command taken from unselected hall panel");
  chk_wd_park: assert property ( // RULE17
    wd_cnt_reg < 32'(LINK_TIMEOUT_CYC))
    else $error("link watchdog ran past its limit");
  chk_open1_follow: assert property ( // RULE7
    ce_i && door_en && can_door_valid_i
      |=> car_open1_relay_o == $past(can_door_open1_i))
    else $error("open 1 relay did not follow bus command");
  chk_car_hold: assert property ( // RULE7
    ce_i && door_en && !can_door_valid_i |=> $stable(car_open1_relay_o))
    else $error("car relay moved without bus command");
  chk_board_hold: assert property ( // RULE8
    ce_i && !can_door_valid_i |=> $stable(board_door_relays_o))
    else $error("board relays moved without bus command");
  chk_board_any: assert property ( // RULE8
    board_door_relays_o[3] == |board_door_relays_o[2:0])
    else $error("board any-door bit out of step");
  chk_door_en_out: assert property ( // RULE18
    ce_i |=> door_serial_en_o == $past(door_en))
    else $error("door enable output not registered");
  chk_ce_freeze: assert property (
    !ce_i |=> $stable(top_limit_o) && $stable(bottom_limit_o)
      && $stable(lock_mode_o) && $stable(fire_mode_o)
      && $stable(board_door_relays_o))
    else $error("outputs moved while clock enable low");

  cov_lock_mode: cover property (
    serial_lock_enable_i && link_ok_reg ##1 lock_mode_o);
  cov_fire_mode: cover property (
    serial_fire_enable_i && link_ok_reg ##1 fire_mode_o);
  cov_link_drop: cover property (link_ok_reg ##1 !link_ok_reg);
  cov_door_cmd: cover property (door_en ##1 car_open1_relay_o);
endmodule : ssr_top
